/* File: core/qspf_consts.svh */
`ifndef QSPF_CONSTS_SVH
`define QSPF_CONSTS_SVH
// Functional notes
// R1 - Deselected: every data line released
// R2 - Ignore everything until first select falling edge
// R3 - No bits taken while select high
// R4 - Select low takes device out of standby
// R5 - Single mode samples line 0 on rising
// R6 - Single mode launches line 1 on falling
// R7 - Dual/quad: lines 0-1 bidirectional, same edges
// R8 - Quad uses protect and pause pins as data
// R9 - Protect bit plus protect pin low blocks writes
// R10 - Protect bit clear: status writes always allowed
// R11 - Quad enable disables pin write protection
// R12 - Quad enable disables pin pause function
// R13 - Pause keeps partial sequence intact
// R14 - Pause while selected releases output line
// R15 - Pause pin high resumes transfer
// R16 - Modes 0 and 3, same edges
// R17 - Host drives unused protect/pause pins
// R18 - Quad enable is status bit 6, default 0
// R19 - Pause freezes counters and shifters
// R20 - Select rising ends transfer, releases lines
`define QSPF_ADDR_W    4
`define QSPF_OFF_CTRL  4'h0
`define QSPF_OFF_STREG 4'h1
`define QSPF_OFF_TXD   4'h2
`define QSPF_OFF_RXD   4'h3
`define QSPF_OFF_STATE 4'h4
`define QSPF_CTRL_DIR  2
`define QSPF_SR_BP_LSB 2
`define QSPF_SR_QE     6
`define QSPF_SR_STATUS_WRITE_DISABLE_BIT   7
`define QSPF_SR_WMASK  8'hfc
`define QSPF_SR_RST    8'h00
`define QSPF_CTRL_RST  3'h0
`define QSPF_ST_BLK    5
`endif

/* File: core/qspf_pkg.sv */
package qspf_pkg;
  typedef enum logic [1:0] {
    w_single = 2'h0,
    w_dual   = 2'h1,
    w_quad   = 2'h3
  } qspf_width_t;
  typedef enum logic [1:0] {
    st_unarmed = 2'h0,
    st_standby = 2'h1,
    st_active  = 2'h3,
    st_paused  = 2'h2
  } qspf_state_t;
endpackage

/* File: core/qspf_frontend.sv */
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "qspf_consts.svh"
module qspf_frontend #(
  parameter int unsigned DATA_W = 8
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  // Serial pins
  input  wire logic                    sck,
  input  wire logic                    chip_select_n,
  input  wire logic [3:0]              data_line_in,
  output logic      [3:0]              data_line_out,
  output logic      [3:0]              data_line_oe_n,
  // Register port
  input  wire logic [`QSPF_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata
);

  generate
    if (DATA_W != 8) begin : g_chk
      $error("qspf_frontend supports DATA_W of 8 only");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 4 clock, bit 5 select
  logic [5:0]              pin_s1;
  logic [5:0]              pin_s2;
  logic [5:0]              pin_s3;

  // No reset: a select held low through reset must not look like a fresh fall
  always_ff @(posedge core_clk) begin
    pin_s1 <= {chip_select_n, sck, data_line_in};
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  logic                    sck_rise;
  logic                    sck_fall;
  logic                    cs_fall;
  logic                    cs_low;
  logic [3:0]              din;
  assign sck_rise = pin_s2[4] & ~pin_s3[4];
  assign sck_fall = ~pin_s2[4] & pin_s3[4];
  assign cs_fall  = ~pin_s2[5] & pin_s3[5];
  assign cs_low   = ~pin_s2[5];
  assign din      = pin_s2[3:0];

  ////////////////////////////////////////////////////////////////////////
  // State
  qspf_pkg::qspf_state_t   state;
  qspf_pkg::qspf_state_t   next_state;
  logic [2:0]              ctrl;
  logic [2:0]              next_ctrl;
  logic [7:0]              sreg;
  logic [7:0]              next_sreg;
  logic [7:0]              rx_sh;
  logic [7:0]              next_rx_sh;
  logic [2:0]              rx_cnt;
  logic [2:0]              next_rx_cnt;
  logic [7:0]              rx_data;
  logic [7:0]              next_rx_data;
  logic                    rx_full;
  logic                    next_rx_full;
  logic [7:0]              tx_sh;
  logic [7:0]              next_tx_sh;
  logic [2:0]              tx_cnt;
  logic [2:0]              next_tx_cnt;
  logic [7:0]              tx_data;
  logic [7:0]              next_tx_data;
  logic                    tx_empty;
  logic                    next_tx_empty;
  logic                    launched;
  logic                    next_launched;
  logic                    wr_blk;
  logic                    next_wr_blk;
  logic [3:0]              next_out;
  logic [3:0]              next_oe_n;
  logic [7:0]              next_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Width decode
  qspf_pkg::qspf_width_t   weff;
  logic [3:0]              step;
  logic [3:0]              mask;
  logic                    qe;
  logic                    pause;
  logic                    sr_lock;

  assign qe      = sreg[`QSPF_SR_QE];                                   // R18
  assign pause   = ~qe & ~din[3];                                       // R12
  assign sr_lock = sreg[`QSPF_SR_STATUS_WRITE_DISABLE_BIT] & ~din[2] & ~qe;                 // R9 R10 R11

  always_comb begin
    unique case (ctrl[1:0])
      2'h3: weff = qe ? qspf_pkg::w_quad : qspf_pkg::w_dual;            // R8
      2'h1: weff = qspf_pkg::w_dual;
      default: weff = qspf_pkg::w_single;
    endcase
    unique case (weff)
      qspf_pkg::w_quad: begin
        step = 4'h4;
        mask = 4'hf;
      end
      qspf_pkg::w_dual: begin
        step = 4'h2;
        mask = 4'h3;
      end
      default: begin
        step = 4'h1;
        mask = 4'h2;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath
  logic                    active;
  logic                    dir_tx;
  logic                    rx_take;
  logic                    tx_take;
  logic [3:0]              rx_sum;
  logic [3:0]              tx_sum;
  logic [7:0]              rx_shifted;
  logic [7:0]              cur;
  logic [3:0]              out_bits;

  assign active  = (state == qspf_pkg::st_active) & cs_low;             // R3 R4 R19
  assign dir_tx  = ctrl[`QSPF_CTRL_DIR];
  assign rx_take = active & sck_rise & (~dir_tx | (weff == qspf_pkg::w_single)); // R5 R7
  assign tx_take = active & sck_fall & dir_tx;                          // R6 R7 R16
  assign rx_sum  = {1'b0, rx_cnt} + step;
  assign tx_sum  = {1'b0, tx_cnt} + step;
  assign cur     = (tx_cnt == 3'h0) ? tx_data : tx_sh;

  always_comb begin
    unique case (weff)
      qspf_pkg::w_quad: begin
        rx_shifted = {rx_sh[3:0], din};
        out_bits   = cur[7:4];
      end
      qspf_pkg::w_dual: begin
        rx_shifted = {rx_sh[5:0], din[1:0]};
        out_bits   = {2'h0, cur[7:6]};
      end
      default: begin
        rx_shifted = {rx_sh[6:0], din[0]};
        out_bits   = {2'h0, cur[7], 1'h0};
      end
    endcase
  end

  always_comb begin
    next_state    = state;
    next_ctrl     = ctrl;
    next_sreg     = sreg;
    next_rx_sh    = rx_sh;
    next_rx_cnt   = rx_cnt;
    next_rx_data  = rx_data;
    next_tx_sh    = tx_sh;
    next_tx_cnt   = tx_cnt;
    next_tx_data  = tx_data;
    next_launched = launched;
    next_out      = data_line_out;
    next_rdata    = 8'h00;
    unique case (state)
      qspf_pkg::st_unarmed: if (cs_fall) next_state = qspf_pkg::st_active; // R2
      qspf_pkg::st_standby: if (cs_fall) next_state = qspf_pkg::st_active; // R4
      qspf_pkg::st_active: begin
        if (!cs_low) next_state = qspf_pkg::st_standby;                 // R20
        else if (pause) next_state = qspf_pkg::st_paused;               // R13
      end
      qspf_pkg::st_paused: begin
        if (!cs_low) next_state = qspf_pkg::st_standby;
        else if (!pause) next_state = qspf_pkg::st_active;              // R15
      end
    endcase
    if (rx_take) begin
      next_rx_sh  = rx_shifted;
      next_rx_cnt = rx_sum[2:0];
      if (rx_sum[3]) next_rx_data = rx_shifted;
    end
    if (tx_take) begin
      next_tx_sh    = cur << step;
      next_tx_cnt   = tx_sum[2:0];
      next_launched = 1'b1;
      next_out      = out_bits;
    end
    if (next_state == qspf_pkg::st_standby) begin                       // R20
      next_rx_cnt   = 3'h0;
      next_tx_cnt   = 3'h0;
      next_launched = 1'b0;
    end
    // Lines driven only while selected, unpaused and launching
    next_oe_n = 4'hf;                                                   // R1 R14
    if (next_state == qspf_pkg::st_active && next_launched && dir_tx)
      next_oe_n = ~mask;
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `QSPF_OFF_CTRL: next_ctrl = reg_wdata[2:0];
        `QSPF_OFF_STREG:
          if (!sr_lock)                                                 // R9 R10
            next_sreg = reg_wdata & `QSPF_SR_WMASK;
        `QSPF_OFF_TXD: next_tx_data = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `QSPF_OFF_CTRL:  next_rdata = {5'h00, ctrl};
        `QSPF_OFF_STREG: next_rdata = sreg;
        `QSPF_OFF_TXD:   next_rdata = tx_data;
        `QSPF_OFF_RXD:   next_rdata = rx_data;
        `QSPF_OFF_STATE: next_rdata = {2'h0, wr_blk, tx_empty, rx_full,
                                       state == qspf_pkg::st_paused,
                                       state[1],
                                       state != qspf_pkg::st_unarmed};
        default: next_rdata = 8'h00;
      endcase
    end
    // Hardware set wins over software clear
    next_rx_full  = (rx_take & rx_sum[3]) |
                    (rx_full & ~(reg_rd & reg_addr == `QSPF_OFF_RXD));
    next_tx_empty = (tx_take & tx_cnt == 3'h0) |
                    (tx_empty & ~(reg_wr & reg_addr == `QSPF_OFF_TXD));
    next_wr_blk   = (reg_wr & reg_addr == `QSPF_OFF_STREG & sr_lock) |
                    (wr_blk & ~(reg_wr & reg_addr == `QSPF_OFF_STATE &
                                reg_wdata[`QSPF_ST_BLK]));
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state          <= qspf_pkg::st_unarmed;
      ctrl           <= `QSPF_CTRL_RST;
      sreg           <= `QSPF_SR_RST;                                   // R18
      rx_sh          <= 8'h00;
      rx_cnt         <= 3'h0;
      rx_data        <= 8'h00;
      rx_full        <= 1'b0;
      tx_sh          <= 8'h00;
      tx_cnt         <= 3'h0;
      tx_data        <= 8'h00;
      tx_empty       <= 1'b1;
      launched       <= 1'b0;
      wr_blk         <= 1'b0;
      data_line_out  <= 4'h0;
      data_line_oe_n <= 4'hf;
      reg_rdata      <= 8'h00;
    end else begin
      state          <= next_state;
      ctrl           <= next_ctrl;
      sreg           <= next_sreg;
      rx_sh          <= next_rx_sh;
      rx_cnt         <= next_rx_cnt;
      rx_data        <= next_rx_data;
      rx_full        <= next_rx_full;
      tx_sh          <= next_tx_sh;
      tx_cnt         <= next_tx_cnt;
      tx_data        <= next_tx_data;
      tx_empty       <= next_tx_empty;
      launched       <= next_launched;
      wr_blk         <= next_wr_blk;
      data_line_out  <= next_out;
      data_line_oe_n <= next_oe_n;
      reg_rdata      <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_desel_hiz;
    (state == qspf_pkg::st_unarmed || state == qspf_pkg::st_standby)
      |-> data_line_oe_n == 4'hf;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz) else $error("lines driven while deselected"); // R1

  property p_unarmed;
    (state == qspf_pkg::st_unarmed && !cs_fall) |=> state == qspf_pkg::st_unarmed;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("armed without select fall"); // R2

  property p_no_take;
    (state != qspf_pkg::st_active) |=> $stable(rx_data) && !$rose(rx_full);
  endproperty
  a_no_take: assert property (p_no_take) else $error("bits taken while not active"); // R3

  property p_select;
    (state == qspf_pkg::st_standby && cs_fall) |=> state == qspf_pkg::st_active;
  endproperty
  a_select: assert property (p_select) else $error("select fall did not activate"); // R4

  property p_sample;
    (rx_take && weff == qspf_pkg::w_single) |=> rx_sh[0] == $past(din[0]);
  endproperty
  a_sample: assert property (p_sample) else $error("single bit not sampled"); // R5

  property p_launch;
    (tx_take && !pause) |=> data_line_oe_n[1] == 1'b0 ##1 1'b1;
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not drive line 1"); // R6 R7

  property p_quad;
    (tx_take && weff == qspf_pkg::w_quad) |=> data_line_out[3] == $past(cur[7]);
  endproperty
  a_quad: assert property (p_quad) else $error("quad line 3 wrong"); // R8

  property p_lock;
    (reg_wr && reg_addr == `QSPF_OFF_STREG && sr_lock) |=> $stable(sreg) && wr_blk;
  endproperty
  a_lock: assert property (p_lock) else $error("locked status written"); // R9

  property p_pause;
    (state == qspf_pkg::st_paused && cs_low && pause)
      |=> $stable(rx_cnt) && $stable(tx_cnt) && data_line_oe_n[1];
  endproperty
  a_pause: assert property (p_pause) else $error("pause not frozen"); // R14 R19

  property p_resume;
    (state == qspf_pkg::st_paused && !pause && cs_low) |=> state == qspf_pkg::st_active;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume"); // R15

  property p_end;
    (state == qspf_pkg::st_active && !cs_low) |=> rx_cnt == 3'h0 && data_line_oe_n == 4'hf;
  endproperty
  a_end: assert property (p_end) else $error("transfer not ended"); // R20

  c_pause:  cover property (state == qspf_pkg::st_paused ##[1:200] state == qspf_pkg::st_active);
  c_rxbyte: cover property ($rose(rx_full));
  c_quadtx: cover property (tx_take && weff == qspf_pkg::w_quad);

endmodule // qspf_frontend

/* File: tb/qspf_host.sv */
`timescale 1ns/1ps
module qspf_host (
  // Clock
  input  wire logic       core_clk,
  // Link pins
  output logic            sck,
  output logic            chip_select_n,
  output logic [3:0]      host_line,
  output logic [3:0]      host_drv,
  input  wire logic [3:0] pin
);
  initial begin
    sck = 1'b1;
    chip_select_n = 1'b0;
    host_line = 4'hc;
    host_drv = 4'hd;
  end
  ////////////////////////////////////////////////////////////////
  task automatic pins(input logic wp, input logic hold);
    @(posedge core_clk);
    host_line[3:2] <= {hold, wp};
    repeat (6) @(posedge core_clk);
  endtask
  task automatic sel(input logic v);
    @(posedge core_clk);
    chip_select_n <= v;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic idle(input logic v);
    @(posedge core_clk);
    sck <= v;
    repeat (8) @(posedge core_clk);
  endtask
  // Each bit: falling edge with new data, rising edge later; sample just before it
  task automatic xfer(input int w, input int n, input logic [7:0] tx, input bit dtx,
                      output logic [7:0] rx);
    logic [1:0] ph;
    logic [3:0] m;
    int         r;
    ph = host_line[3:2];
    m = 4'((1 << w) - 1);
    r = 0;
    host_drv <= (w == 1) ? 4'hd : (dtx ? ((w == 2) ? 4'hc : 4'h0) : 4'hf);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      sck <= 1'b0;
      host_line <= (host_line & ~m) | (4'(tx >> (8 - w * (i + 1))) & m);
      repeat (8) @(posedge core_clk);
      r = (r << w) | ((w == 1) ? int'(pin[1]) : int'(pin & m));
      sck <= 1'b1;
      repeat (8) @(posedge core_clk);
    end
    host_line[3:2] <= ph;
    host_drv <= 4'hd;
    rx = 8'(r);
  endtask
endmodule // qspf_host

/* File: tb/tb_quad_spi_flash_pin_frontend.sv */
`timescale 1ns/1ps
module tb_quad_spi_flash_pin_frontend;
  logic       core_clk;
  logic       sys_rst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [3:0] filler    = 4'h5;
  logic       sck;
  logic       cs_n;
  logic [3:0] hl;
  logic [3:0] hd;
  logic [3:0] pin;
  logic [3:0] dout;
  logic [3:0] doe_n;
  logic [7:0] rdata;
  logic [7:0] rx;
  logic [7:0] b;
  logic [31:0] seed = 32'h9df1;
  logic [7:0] exp_q[$];
  int         n_fail = 0;
  int         n_tests = 0;
  logic [7:0] wrv [6] = '{8'h83, 8'h3c, 8'hbc, 8'hc0, 8'hc4, 8'h40};
  logic [7:0] expv [6] = '{8'h80, 8'h80, 8'hbc, 8'hc0, 8'hc4, 8'h40};
  logic       wpv [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) filler <= ~filler;
  // Released lines show a changing pattern, never the last value
  assign pin = (~doe_n & dout) | (doe_n & hd & hl) | (doe_n & ~hd & filler);
  qspf_frontend #(.DATA_W(8)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .sck(sck), .chip_select_n(cs_n),
    .data_line_in(pin), .data_line_out(dout), .data_line_oe_n(doe_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata));
  qspf_host host (
    .core_clk(core_clk), .sck(sck), .chip_select_n(cs_n), .host_line(hl),
    .host_drv(hd), .pin(pin));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rndb();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0] & 8'h7f;
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] e);
    n_tests++;
    if (seen !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(nm, rdata, e);
  endtask
  // Half a byte, a pause with junk edges, then the other half
  task automatic pause_byte(input bit dtx, input logic [7:0] v, output logic [7:0] r);
    logic [7:0] a;
    logic [7:0] c;
    host.xfer(1, 4, v, dtx, a);
    host.pins(1'b1, 1'b0);
    check("pause oe", {4'h0, doe_n}, 8'h0f);
    host.xfer(1, 4, ~v, 1'b0, c);
    host.pins(1'b1, 1'b1);
    host.xfer(1, 4, v << 4, dtx, c);
    r = {a[3:0], c[3:0]};
  endtask
  task automatic give_verdict();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    n_fail++;
    give_verdict();
  end
  initial core_clk = 1'b0;
  initial begin
    sys_rst   <= 1'b1;
    reg_addr  <= 4'h0;
    reg_wdata <= 8'h00;
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1 check("reset oe", {4'h0, doe_n}, 8'h0f);
    rdc("status reset", 4'h1, 8'h00);
    host.xfer(1, 8, rndb(), 1'b0, rx);
    rdc("unarmed", 4'h4, 8'h10);
    host.sel(1'b1);
    host.xfer(1, 8, rndb(), 1'b0, rx);
    rdc("deselected", 4'h4, 8'h10);
    host.sel(1'b0);
    rdc("selected", 4'h4, 8'h13);
    host.xfer(1, 5, 8'hff, 1'b0, rx);
    host.sel(1'b1);
    host.sel(1'b0);
    b = rndb();
    exp_q.push_back(b);
    host.idle(1'b0);
    host.xfer(1, 8, b, 1'b0, rx);
    host.idle(1'b0);
    rdc("byte state", 4'h4, 8'h1b);
    rdc("mode0 rx", 4'h3, exp_q.pop_front());
    host.sel(1'b1);
    host.idle(1'b1);
    rdc("unmapped", 4'hf, 8'h00);
    wr(4'hf, 8'hff);
    b = rndb();
    wr(4'h0, 8'h00);
    host.sel(1'b0);
    pause_byte(1'b0, b, rx);
    host.sel(1'b1);
    rdc("paused rx", 4'h3, b);
    b = rndb();
    wr(4'h2, b);
    wr(4'h0, 8'h04);
    host.sel(1'b0);
    pause_byte(1'b1, 8'h00, rx);
    host.sel(1'b1);
    check("paused tx", rx, b);
    rdc("tx echo", 4'h3, 8'h00);
    for (int i = 0; i < 6; i++) begin
      host.pins(wpv[i], 1'b1);
      wr(4'h1, wrv[i]);
      rdc("status", 4'h1, expv[i]);
      if (i == 1) begin
        rdc("blocked", 4'h4, 8'h31);
        wr(4'h4, 8'h20);
        rdc("unblocked", 4'h4, 8'h11);
      end
    end
    host.pins(1'b1, 1'b1);
    for (int k = 0; k < 3; k++) begin
      b = rndb();
      exp_q.push_back(b);
      wr(4'h0, (k == 2) ? 8'h03 : 8'(k));
      host.sel(1'b0);
      host.xfer(1 << k, 8 >> k, b, 1'b0, rx);
      host.sel(1'b1);
      rdc("rx width", 4'h3, exp_q.pop_front());
      b = rndb();
      wr(4'h2, b);
      wr(4'h0, (k == 2) ? 8'h07 : 8'(k + 4));
      host.sel(1'b0);
      host.xfer(1 << k, 8 >> k, 8'h00, 1'b1, rx);
      host.sel(1'b1);
      check("tx width", rx, b);
      check("end oe", {4'h0, doe_n}, 8'h0f);
    end
    give_verdict();
  end
endmodule // tb_quad_spi_flash_pin_frontend
